/* bench/itd_mem_model.sv */
`timescale 1ns/10ps

// Far-side memories: tallies requests landing in each space
module itd_mem_model (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic xdm_req_in,
    input wire logic xdm_write_in,
    input wire logic [1:0] xdm_target_in,
    input wire logic [15:0] xdm_addr_in,
    input wire logic code_fetch_in,
    output logic [7:0] onchip_count_out,
    output logic [7:0] offchip_count_out,
    output logic [7:0] flash_count_out,
    output logic [7:0] code_count_out
);
    // Counted only where the address fits the space; flash takes writes
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            onchip_count_out <= 8'h00;
            offchip_count_out <= 8'h00;
            flash_count_out <= 8'h00;
            code_count_out <= 8'h00;
        end else begin
            if (xdm_req_in) begin
                case (xdm_target_in)
                    2'h1: if (xdm_addr_in < 16'h1000) begin
                        onchip_count_out <= onchip_count_out + 8'h01;
                    end
                    2'h2: if (xdm_addr_in >= 16'h1000) begin
                        offchip_count_out <= offchip_count_out + 8'h01;
                    end
                    2'h3: if (xdm_write_in) begin
                        flash_count_out <= flash_count_out + 8'h01;
                    end
                    default: ;
                endcase
            end
            if (code_fetch_in) begin
                code_count_out <= code_count_out + 8'h01;
            end
        end
    end
endmodule // itd_mem_model

/* bench/tb_top.sv */
`timescale 1ns/10ps

module tb_top;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic instr_valid_in = 1'b0;
    logic [4:0] instr_class_in = 5'h00;
    logic [7:0] acc_in = 8'h00;
    logic [15:0] pc_in = 16'h0000;
    logic [15:0] data_pointer_in = 16'h0000;
    logic [7:0] ptr_addr_in = 8'h00;
    logic [7:0] xdata_page_in = 8'h00;
    logic flash_write_en_in = 1'b0;
    logic ready_out, pc_advance_out, stall_out, done_out, illegal_out;
    logic xdm_req_out, xdm_write_out, code_fetch_out;
    logic [1:0] pc_step_out, xdm_target_out;
    logic [3:0] cycles_out;
    logic [15:0] xdm_addr_out, code_addr_out;
    logic [7:0] n_on, n_off, n_fl, n_code;
    int bad_count = 0;
    int total_checks = 0;

    itd_decoder itd_decoder_i (.sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
        .instr_class_in(instr_class_in), .acc_in(acc_in), .pc_in(pc_in),
        .data_pointer_in(data_pointer_in), .ptr_addr_in(ptr_addr_in),
        .xdata_page_in(xdata_page_in), .flash_write_en_in(flash_write_en_in),
        .ready_out(ready_out), .pc_advance_out(pc_advance_out),
        .pc_step_out(pc_step_out), .cycles_out(cycles_out),
        .stall_out(stall_out), .done_out(done_out),
        .illegal_out(illegal_out), .xdm_req_out(xdm_req_out),
        .xdm_write_out(xdm_write_out), .xdm_target_out(xdm_target_out),
        .xdm_addr_out(xdm_addr_out), .code_fetch_out(code_fetch_out),
        .code_addr_out(code_addr_out));

    itd_mem_model itd_mem_model_i (.sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in), .xdm_req_in(xdm_req_out),
        .xdm_write_in(xdm_write_out), .xdm_target_in(xdm_target_out),
        .xdm_addr_in(xdm_addr_out), .code_fetch_in(code_fetch_out),
        .onchip_count_out(n_on), .offchip_count_out(n_off),
        .flash_count_out(n_fl), .code_count_out(n_code));

    // 50 ns period
    initial begin
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Expected {length, cycles} per class, unknown codes count as 1/1
    function automatic logic [5:0] exp_lc(input logic [4:0] c);
        case (c)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: return {2'h1, 4'h3};
            5'h08, 5'h12, 5'h15: return {2'h1, 4'h2};
            5'h07, 5'h09, 5'h0B, 5'h0F, 5'h11, 5'h14, 5'h16, 5'h17:
                return {2'h2, 4'h2};
            5'h0A, 5'h0D, 5'h0E: return {2'h3, 4'h3};
            default: return {2'h1, 4'h1};
        endcase
    endfunction

    // One instruction, judged cycle by cycle until done
    task automatic issue(input logic [4:0] c);
        logic [5:0] lc;
        int n;
        lc = exp_lc(c);
        n = int'(lc[3:0]);
        while (ready_out !== 1'b1) @(posedge sys_clk_in);
        instr_valid_in <= 1'b1;
        instr_class_in <= c;
        @(posedge sys_clk_in);
        instr_valid_in <= 1'b0;
        #1;
        chk("pc_advance", 16'(pc_advance_out), 16'h0001);
        chk("pc_step", 16'(pc_step_out), 16'(lc[5:4]));
        chk("cycles", 16'(cycles_out), 16'(lc[3:0]));
        chk("illegal", 16'(illegal_out), 16'(c > 5'h18));
        for (int k = 1; k <= n; k++) begin
            if (k > 1) begin
                @(posedge sys_clk_in);
                #1;
                chk("pc_adv_low", 16'(pc_advance_out), 16'h0000);
            end
            chk("stall", 16'(stall_out), 16'(k < n));
            chk("done", 16'(done_out), 16'(k == n));
            chk("ready", 16'(ready_out), 16'(k == n));
        end
        @(posedge sys_clk_in);
    endtask

    task automatic test_reset();
        #1;
        chk("rst_ready", 16'(ready_out), 16'h0001);
        chk("rst_step", 16'(pc_step_out), 16'h0001);
        chk("rst_cycles", 16'(cycles_out), 16'h0001);
        chk("rst_target", 16'(xdm_target_out), 16'h0000);
        chk("rst_pulses", 16'({stall_out, done_out, xdm_req_out}), 16'h0000);
    endtask

    task automatic test_table();
        for (int c = 0; c <= 5'h18; c++) begin
            issue(5'(c));
        end
        issue(5'h1F);
    endtask

    // Route cases: class, flash enable, page, pointer, data_pointer, addr, target
    task automatic xdm_case(input logic [4:0] c, input logic fe,
                            input logic [7:0] pg, input logic [7:0] pa,
                            input logic [15:0] dp, input logic [15:0] ea,
                            input logic [1:0] et);
        flash_write_en_in <= fe;
        xdata_page_in <= pg;
        ptr_addr_in <= pa;
        data_pointer_in <= dp;
        issue(c);
        chk("xdm_addr", xdm_addr_out, ea);
        chk("xdm_target", 16'(xdm_target_out), 16'(et));
        chk("xdm_write", 16'(xdm_write_out), 16'(c[0]));
    endtask

    task automatic test_route();
        xdm_case(5'h00, 1'b1, 8'h0F, 8'hFF, 16'hAAAA, 16'h0FFF, 2'h1);
        xdm_case(5'h01, 1'b0, 8'h10, 8'h00, 16'h5555, 16'h1000, 2'h2);
        xdm_case(5'h02, 1'b1, 8'h00, 8'h00, 16'h1000, 16'h1000, 2'h2);
        xdm_case(5'h03, 1'b1, 8'h00, 8'h00, 16'h0000, 16'h0000, 2'h3);
        xdm_case(5'h03, 1'b0, 8'h00, 8'h00, 16'h0FFF, 16'h0FFF, 2'h1);
        chk("far_onchip", 16'(n_on), 16'h0006);
        chk("far_offchip", 16'(n_off), 16'h0002);
        chk("far_flash", 16'(n_fl), 16'h0001);
    endtask

    task automatic test_code();
        acc_in <= 8'h20;
        data_pointer_in <= 16'hFFF0;
        pc_in <= 16'h1234;
        issue(5'h04);
        chk("code_dp", code_addr_out, 16'h0010);
        acc_in <= 8'hFF;
        issue(5'h05);
        chk("code_pc", code_addr_out, 16'h1333);
        chk("far_code", 16'(n_code), 16'h0004);
    endtask

    // Valid held high: busy cycles refuse, 1-cycle classes stream
    task automatic held_valid(input logic [4:0] c, input int exp);
        int pulses;
        pulses = 0;
        while (ready_out !== 1'b1) @(posedge sys_clk_in);
        instr_valid_in <= 1'b1;
        instr_class_in <= c;
        for (int k = 0; k < 6; k++) begin
            @(posedge sys_clk_in);
            if (k == 5) instr_valid_in <= 1'b0;
            #1;
            if (pc_advance_out === 1'b1) pulses++;
        end
        chk("accepts", 16'(pulses), 16'(exp));
        repeat (4) @(posedge sys_clk_in);
    endtask

    // Watchdog well past the expected run of about 150 cycles
    initial begin
        #(50 * 5000);
        bad_count++;
        results();
    end

    initial begin
        repeat (4) @(posedge sys_clk_in);
        test_reset();
        @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        test_table();
        test_route();
        test_code();
        held_valid(5'h0D, 2);
        held_valid(5'h06, 6);
        held_valid(5'h08, 3);
        results();
    end
endmodule // tb_top

/* design/itd_class_table.sv */
`timescale 1ns/10ps
`include "itd_map.svh"

module itd_class_table (
    input wire logic [4:0] class_in,
    output itd_pkg::itd_len_t len_out,
    output itd_pkg::itd_cyc_t cyc_out,
    output logic legal_out,
    output logic xdm_out,
    output logic xdm_write_out,
    output logic xdm_dp_out,
    output logic cbm_out,
    output logic cbm_pc_out
);

    // Length and time per class; unknown classes act as one-cycle no-ops
    always_comb begin
        len_out = `ITD_LEN_1;
        cyc_out = `ITD_CYC_1;
        legal_out = 1'b1;
        xdm_out = 1'b0;
        xdm_write_out = 1'b0;
        xdm_dp_out = 1'b0;
        cbm_out = 1'b0;
        cbm_pc_out = 1'b0;
        case (itd_pkg::itd_class_t'(class_in))
            itd_pkg::ITD_XDM_PTR_RD,
            itd_pkg::ITD_XDM_PTR_WR,
            itd_pkg::ITD_XDM_DP_RD,
            itd_pkg::ITD_XDM_DP_WR: begin
                cyc_out = `ITD_CYC_3;
                xdm_out = 1'b1;
                xdm_write_out = class_in[0];
                xdm_dp_out = class_in[1];
            end
            itd_pkg::ITD_CBM_DP,
            itd_pkg::ITD_CBM_PC: begin
                cyc_out = `ITD_CYC_3;
                cbm_out = 1'b1;
                cbm_pc_out = class_in[0];
            end
            itd_pkg::ITD_ACC_REG,
            itd_pkg::ITD_ACC_UNARY,
            itd_pkg::ITD_XCH_REG,
            itd_pkg::ITD_CARRY_OP,
            itd_pkg::ITD_NOP: begin
                cyc_out = `ITD_CYC_1;
            end
            itd_pkg::ITD_ACC_DIR,
            itd_pkg::ITD_ACC_IMM,
            itd_pkg::ITD_LOG_DIR_ACC,
            itd_pkg::ITD_PUSH_POP,
            itd_pkg::ITD_XCH_DIR,
            itd_pkg::ITD_BIT_OP,
            itd_pkg::ITD_MOV_VAL_IND,
            itd_pkg::ITD_MOV_VAL_REG: begin
                len_out = `ITD_LEN_2;
                cyc_out = `ITD_CYC_2;
            end
            itd_pkg::ITD_ACC_IND,
            itd_pkg::ITD_XCH_IND,
            itd_pkg::ITD_MOV_ACC_IND: begin
                cyc_out = `ITD_CYC_2;
            end
            itd_pkg::ITD_LOG_DIR_IMM,
            itd_pkg::ITD_MOV_DIR_DIR,
            itd_pkg::ITD_LOAD_DP_IMM: begin
                len_out = `ITD_LEN_3;
                cyc_out = `ITD_CYC_3;
            end
            default: begin
                legal_out = 1'b0;
            end
        endcase
    end

endmodule // itd_class_table

/* design/itd_decoder.sv */
// Functional notes
// - External data move reaches on-chip RAM, off-chip RAM or flash.
// - Every external data move form: one byte, three cycles.
// - Code byte move at A plus pointer or PC: one byte, three cycles.
// - Accumulator ops with working register: one byte, one cycle.
// - Accumulator ops with direct byte: two bytes, two cycles.
// - Accumulator ops with indirect RAM: one byte, two cycles.
// - Accumulator ops with immediate: two bytes, two cycles.
// - Logic immediate into direct byte: three bytes, three cycles.
// - Logic accumulator into direct byte: two bytes, two cycles.
// - Single-operand accumulator ops: one byte, one cycle.
// - Direct to direct move: three bytes, three cycles.
// - Load data pointer with 16-bit constant: three bytes, three cycles.
// - Push and pop of direct byte: two bytes, two cycles.
// - Exchange: register 1/1, direct 2/2, indirect and low nibble 1/2.
// - Carry ops 1/1; direct bit ops and bit AND to carry 2/2.
// - Accumulator to indirect 1/2; direct or immediate to indirect 2/2.
// - Direct or immediate into working register: two bytes, two cycles.
// - Timing counts plain system clocks, no machine-cycle grouping.
`timescale 1ns/10ps
`include "itd_map.svh"

module itd_decoder #(
    parameter int ONCHIP_XDATA_BYTES = `ITD_ONCHIP_XDATA_BYTES
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic instr_valid_in,
    input wire logic [4:0] instr_class_in,
    input wire logic [7:0] acc_in,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] data_pointer_in,
    input wire logic [7:0] ptr_addr_in,
    input wire logic [7:0] xdata_page_in,
    input wire logic flash_write_en_in,
    output logic ready_out,
    output logic pc_advance_out,
    output logic [1:0] pc_step_out,
    output logic [3:0] cycles_out,
    output logic stall_out,
    output logic done_out,
    output logic illegal_out,
    output logic xdm_req_out,
    output logic xdm_write_out,
    output logic [1:0] xdm_target_out,
    output logic [15:0] xdm_addr_out,
    output logic code_fetch_out,
    output logic [15:0] code_addr_out
);

    itd_pkg::itd_len_t dec_len;
    itd_pkg::itd_cyc_t dec_cyc;
    logic dec_legal;
    logic dec_xdm;
    logic dec_xdm_wr;
    logic dec_xdm_dp;
    logic dec_cbm;
    logic dec_cbm_pc;
    logic [15:0] route_addr;
    itd_pkg::itd_target_t route_target;
    logic accept;

    itd_pkg::itd_state_t state;
    itd_pkg::itd_state_t next_state;
    itd_pkg::itd_cyc_t remain;
    itd_pkg::itd_cyc_t next_remain;
    logic next_ready;
    logic next_pc_advance;
    logic [1:0] next_pc_step;
    logic [3:0] next_cycles;
    logic next_stall;
    logic next_done;
    logic next_illegal;
    logic next_xdm_req;
    logic next_xdm_write;
    logic [1:0] next_xdm_target;
    logic [15:0] next_xdm_addr;
    logic next_code_fetch;
    logic [15:0] next_code_addr;

    // Class lookup: length and execution time per instruction class
    itd_class_table u_table (
        .class_in(instr_class_in),
        .len_out(dec_len),
        .cyc_out(dec_cyc),
        .legal_out(dec_legal),
        .xdm_out(dec_xdm),
        .xdm_write_out(dec_xdm_wr),
        .xdm_dp_out(dec_xdm_dp),
        .cbm_out(dec_cbm),
        .cbm_pc_out(dec_cbm_pc)
    );

    // Target steering for the external data move
    itd_xdm_route #(
        .ONCHIP_BYTES(ONCHIP_XDATA_BYTES)
    ) u_route (
        .use_dp_in(dec_xdm_dp),
        .is_write_in(dec_xdm_wr),
        .flash_write_en_in(flash_write_en_in),
        .ptr_addr_in(ptr_addr_in),
        .xdata_page_in(xdata_page_in),
        .data_pointer_in(data_pointer_in),
        .addr_out(route_addr),
        .target_out(route_target)
    );

    // An instruction is taken only while the sequencer is idle
    assign accept = instr_valid_in && ready_out;

    // Next-state logic for the timing sequencer
    always_comb begin
        next_state = state;
        next_remain = remain;
        next_ready = ready_out;
        next_pc_advance = 1'b0;
        next_pc_step = pc_step_out;
        next_cycles = cycles_out;
        next_stall = stall_out;
        next_done = 1'b0;
        next_illegal = 1'b0;
        next_xdm_req = 1'b0;
        next_xdm_write = xdm_write_out;
        next_xdm_target = xdm_target_out;
        next_xdm_addr = xdm_addr_out;
        next_code_fetch = 1'b0;
        next_code_addr = code_addr_out;
        case (state)
            itd_pkg::ITD_ST_IDLE: begin
                if (accept) begin
                    // PC moves by the length once, on the first cycle
                    next_pc_advance = 1'b1;
                    next_pc_step = dec_len;
                    next_cycles = dec_cyc;
                    next_illegal = !dec_legal;
                    if (dec_xdm) begin
                        next_xdm_req = 1'b1;
                        next_xdm_write = dec_xdm_wr;
                        next_xdm_target = route_target;
                        next_xdm_addr = route_addr;
                    end
                    if (dec_cbm) begin
                        // Base plus unsigned accumulator, wraps at 64K
                        next_code_fetch = 1'b1;
                        next_code_addr = (dec_cbm_pc ? pc_in
                            : data_pointer_in) + {`ITD_BYTE_ZERO, acc_in};
                    end
                    // Each clock counts one unit of execution time
                    if (dec_cyc == `ITD_CYC_1) begin
                        next_done = 1'b1;
                    end else begin
                        next_state = itd_pkg::ITD_ST_EXEC;
                        next_remain = dec_cyc - `ITD_CYC_1;
                        next_ready = 1'b0;
                        next_stall = 1'b1;
                    end
                end
            end
            itd_pkg::ITD_ST_EXEC: begin
                if (remain == `ITD_CYC_1) begin
                    next_state = itd_pkg::ITD_ST_IDLE;
                    next_remain = `ITD_REMAIN_RST;
                    next_ready = 1'b1;
                    next_stall = 1'b0;
                    next_done = 1'b1;
                end else begin
                    next_remain = remain - `ITD_CYC_1;
                end
            end
            default: begin
                next_state = itd_pkg::ITD_ST_IDLE;
                next_remain = `ITD_REMAIN_RST;
                next_ready = 1'b1;
                next_stall = 1'b0;
            end
        endcase
    end

    // Sequencer registers; every output is one of these
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= itd_pkg::ITD_ST_IDLE;
            remain <= `ITD_REMAIN_RST;
            ready_out <= 1'b1;
            pc_advance_out <= 1'b0;
            pc_step_out <= `ITD_LEN_1;
            cycles_out <= `ITD_CYC_1;
            stall_out <= 1'b0;
            done_out <= 1'b0;
            illegal_out <= 1'b0;
            xdm_req_out <= 1'b0;
            xdm_write_out <= 1'b0;
            xdm_target_out <= itd_pkg::ITD_TGT_NONE;
            xdm_addr_out <= `ITD_ADDR_RST;
            code_fetch_out <= 1'b0;
            code_addr_out <= `ITD_ADDR_RST;
        end else begin
            state <= next_state;
            remain <= next_remain;
            ready_out <= next_ready;
            pc_advance_out <= next_pc_advance;
            pc_step_out <= next_pc_step;
            cycles_out <= next_cycles;
            stall_out <= next_stall;
            done_out <= next_done;
            illegal_out <= next_illegal;
            xdm_req_out <= next_xdm_req;
            xdm_write_out <= next_xdm_write;
            xdm_target_out <= next_xdm_target;
            xdm_addr_out <= next_xdm_addr;
            code_fetch_out <= next_code_fetch;
            code_addr_out <= next_code_addr;
        end
    end

    // Checks on the timing seen by the fetch pipeline
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence one_cycle_s;
        ##1 (done_out && !stall_out);
    endsequence

    sequence two_cycle_s;
        ##1 (stall_out && !done_out) ##1 (done_out && !stall_out);
    endsequence

    sequence three_cycle_s;
        ##1 (stall_out && !done_out) [*2] ##1 (done_out && !stall_out);
    endsequence

    xdm_timing_a: assert property (
        accept && instr_class_in[4:2] == 3'h0
        |-> ##1 (pc_step_out == 2'h1 && xdm_req_out) ##0 1'b1
            ##0 (stall_out && !done_out) [*2] ##1 done_out)
        else $error("external data move not 1 byte 3 cycles");

    flash_route_a: assert property (
        accept && instr_class_in[4:2] == 3'h0 && instr_class_in[0]
            && flash_write_en_in
        |=> xdm_target_out == itd_pkg::ITD_TGT_FLASH && xdm_write_out)
        else $error("flash write not routed to flash");

    code_move_a: assert property (
        accept && instr_class_in == 5'h05
        |-> ##1 (code_fetch_out && pc_step_out == 2'h1
            && code_addr_out == $past(pc_in) + {8'h00, $past(acc_in)}))
        else $error("code byte move fetch address wrong");

    code_time_a: assert property (
        accept && instr_class_in[4:1] == 4'h2 |-> three_cycle_s)
        else $error("code byte move not three cycles");

    acc_reg_a: assert property (
        accept && instr_class_in == 5'h06
        |-> one_cycle_s ##0 (pc_step_out == 2'h1 && ready_out))
        else $error("register operand op not 1 byte 1 cycle");

    acc_dir_a: assert property (
        accept && instr_class_in == 5'h07
        |=> pc_step_out == 2'h2 ##1 done_out && !$past(done_out))
        else $error("direct operand op not 2 bytes 2 cycles");

    acc_ind_a: assert property (
        accept && instr_class_in == 5'h08
        |-> two_cycle_s ##0 pc_step_out == 2'h1)
        else $error("indirect operand op not 1 byte 2 cycles");

    log_imm_a: assert property (
        accept && instr_class_in == 5'h0A
        |-> three_cycle_s ##0 pc_step_out == 2'h3)
        else $error("logic immediate to direct not 3 bytes 3 cycles");

    dp_load_a: assert property (
        accept && instr_class_in == 5'h0E
        |-> three_cycle_s ##0 (pc_step_out == 2'h3 && cycles_out == 4'h3))
        else $error("data pointer load not 3 bytes 3 cycles");

    busy_refuse_a: assert property (
        stall_out |-> !ready_out ##1 !pc_advance_out)
        else $error("new instruction taken while stalled");

    advance_once_a: assert property (
        accept |=> pc_advance_out ##1 (!pc_advance_out || $past(accept)))
        else $error("program counter advance not a single pulse");

endmodule // itd_decoder

/* design/itd_xdm_route.sv */
`timescale 1ns/10ps
`include "itd_map.svh"

module itd_xdm_route #(
    parameter int ONCHIP_BYTES = `ITD_ONCHIP_XDATA_BYTES
) (
    input wire logic use_dp_in,
    input wire logic is_write_in,
    input wire logic flash_write_en_in,
    input wire logic [7:0] ptr_addr_in,
    input wire logic [7:0] xdata_page_in,
    input wire logic [15:0] data_pointer_in,
    output logic [15:0] addr_out,
    output itd_pkg::itd_target_t target_out
);

    localparam logic [16:0] LIMIT = 17'(ONCHIP_BYTES);

    // Refuse a RAM size the 16-bit decode cannot hold
    if (ONCHIP_BYTES < 1 || ONCHIP_BYTES > `ITD_XDATA_SPACE) begin : g_chk
        $error("ONCHIP_BYTES out of range");
    end

    // Writes go to flash while flash writes are enabled, else by address
    always_comb begin
        addr_out = use_dp_in ? data_pointer_in : {xdata_page_in, ptr_addr_in};
        if (is_write_in && flash_write_en_in) begin
            target_out = itd_pkg::ITD_TGT_FLASH;
        end else if ({1'b0, addr_out} < LIMIT) begin
            target_out = itd_pkg::ITD_TGT_ONCHIP;
        end else begin
            target_out = itd_pkg::ITD_TGT_OFFCHIP;
        end
    end

endmodule // itd_xdm_route

/* pkg/itd_map.svh */
`ifndef ITD_MAP_SVH
`define ITD_MAP_SVH

// Encoded lengths in program bytes
`define ITD_LEN_1 2'h1
`define ITD_LEN_2 2'h2
`define ITD_LEN_3 2'h3

// Execution times in system clock cycles
`define ITD_CYC_1 4'h1
`define ITD_CYC_2 4'h2
`define ITD_CYC_3 4'h3

// Size of the on-chip extended data RAM in bytes
`define ITD_ONCHIP_XDATA_BYTES 4096
// Largest external data space, 16-bit address
`define ITD_XDATA_SPACE 65536

// Reset values, and the zero byte that pads the accumulator
`define ITD_ADDR_RST 16'h0000
`define ITD_REMAIN_RST 4'h0
`define ITD_BYTE_ZERO 8'h00

`endif

/* pkg/itd_pkg.sv */
package itd_pkg;

    typedef logic [1:0] itd_len_t;
    typedef logic [3:0] itd_cyc_t;

    // Instruction classes delivered by the predecoder
    typedef enum logic [4:0] {
        ITD_XDM_PTR_RD = 5'h00,
        ITD_XDM_PTR_WR = 5'h01,
        ITD_XDM_DP_RD = 5'h02,
        ITD_XDM_DP_WR = 5'h03,
        ITD_CBM_DP = 5'h04,
        ITD_CBM_PC = 5'h05,
        ITD_ACC_REG = 5'h06,
        ITD_ACC_DIR = 5'h07,
        ITD_ACC_IND = 5'h08,
        ITD_ACC_IMM = 5'h09,
        ITD_LOG_DIR_IMM = 5'h0A,
        ITD_LOG_DIR_ACC = 5'h0B,
        ITD_ACC_UNARY = 5'h0C,
        ITD_MOV_DIR_DIR = 5'h0D,
        ITD_LOAD_DP_IMM = 5'h0E,
        ITD_PUSH_POP = 5'h0F,
        ITD_XCH_REG = 5'h10,
        ITD_XCH_DIR = 5'h11,
        ITD_XCH_IND = 5'h12,
        ITD_CARRY_OP = 5'h13,
        ITD_BIT_OP = 5'h14,
        ITD_MOV_ACC_IND = 5'h15,
        ITD_MOV_VAL_IND = 5'h16,
        ITD_MOV_VAL_REG = 5'h17,
        ITD_NOP = 5'h18
    } itd_class_t;

    // Where an external data move lands
    typedef enum logic [1:0] {
        ITD_TGT_NONE = 2'h0,
        ITD_TGT_ONCHIP = 2'h1,
        ITD_TGT_OFFCHIP = 2'h2,
        ITD_TGT_FLASH = 2'h3
    } itd_target_t;

    typedef enum logic {
        ITD_ST_IDLE = 1'b0,
        ITD_ST_EXEC = 1'b1
    } itd_state_t;

endpackage
